// [design/odt_pkg.sv]
// package: constants and carriers for the on-die termination controller
package odt_pkg;
    // asynchronous turn-on/turn-off delays and clock period: minimum in ns, others in ps
    localparam int ASYNC_MIN_NS  = 2;
    localparam int ASYNC_MAX_PS  = 8500;
    localparam int CLK_PERIOD_PS = 10000;
    // cycles: least rounds up, longest rounds down, never under one
    localparam int ASYNC_MIN_CYC_RAW = (ASYNC_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int ASYNC_MAX_CYC_RAW = ASYNC_MAX_PS / CLK_PERIOD_PS;
    localparam int ASYNC_MIN_CYC = (ASYNC_MIN_CYC_RAW < 1) ? 1 : ASYNC_MIN_CYC_RAW;
    localparam int ASYNC_MAX_CYC = (ASYNC_MAX_CYC_RAW < ASYNC_MIN_CYC) ? ASYNC_MIN_CYC
                                                                     : ASYNC_MAX_CYC_RAW;
    localparam logic [3:0] ASYNC_DELAY = 4'(ASYNC_MIN_CYC);
    // link-clock latency subtrahends
    localparam logic [5:0] ODTL_SUB  = 6'h02;
    localparam logic [5:0] ANPD_SUB  = 6'h01;
    // delay line depth in link clocks
    localparam int         LINE_LEN  = 64;
    localparam logic [5:0] LAT_RESET = 6'h00;

    typedef struct packed {
        logic       rttNomOn;
        logic       rttWrOn;
        logic       dllOffInPpd;   // mode bit 12 of mode register 0 cleared
        logic [4:0] casWriteLat;
        logic [4:0] addLat;
        logic [7:0] refreshCyc;    // refresh cycle time, link clocks
        logic [7:0] exitLockCyc;   // dll-locked exit time, link clocks
    } odt_cfg_t;

    typedef struct packed {
        logic termOn;
        logic asyncMode;
        logic transition;
    } odt_stat_t;

    typedef enum logic [1:0] {
        MODE_SYNC  = 2'b00,
        MODE_ENTRY = 2'b01,
        MODE_ASYNC = 2'b10,
        MODE_EXIT  = 2'b11
    } odt_mode_t;
endpackage

// [design/odt_delay_line.sv]
// shift memory: delays the odt level by a programmable link-clock count
`timescale 1ns/10ps
module odt_delay_line (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    // shift side
    input  wire logic       shiftEn,
    input  wire logic       din,
    // tap side
    input  wire logic [5:0] tap,
    output logic            dout
);
    import odt_pkg::*;

    logic [LINE_LEN-1:0] line;
    logic [LINE_LEN-1:0] next_line;
    logic                next_dout;

    always_comb begin
        next_line = line;
        if (shiftEn) begin
            next_line = {line[LINE_LEN-2:0], din};
        end
        // din and dout are stages of their own, so tap n reads cell n-2
        next_dout = (tap < 6'h02) ? din : line[tap - 6'h02];
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            line <= '0;
            dout <= 1'b0;
        end else begin
            line <= next_line;
            if (shiftEn) begin
                dout <= next_dout;
            end
        end
    end
endmodule // odt_delay_line

// [design/odt_mode_ctrl.sv]
// termination control: sync/async mode selection and power-down transitions
`timescale 1ns/10ps
// Overview of operation
// - async mode when dll off in power-down
// - async mode while dll relocks after reset
// - async path skips additive latency entirely
// - async turn-on within fixed analog window
// - async turn-off within fixed analog window
// - transition windows only with dll-off option
// - entry window starts at first cke low
// - anticipation interval is write latency minus one
// - pending refresh stretches entry window end
// - window change within union of both delays
// - exit window ends dll-lock time after cke high
// - short low pulse merges entry and exit
// - short high pulse merges exit and entry
// - sync latency is cwl plus al minus two
// - sync mode when dll locked, termination enabled
module odt_mode_ctrl (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              resetn,
    // memory link pins
    input  wire logic              linkClk,
    input  wire logic              cke,
    input  wire logic              odt,
    // device state
    input  wire odt_pkg::odt_cfg_t cfg,
    input  wire logic              dllRelocking,
    input  wire logic              refreshCmd,
    // termination status
    output odt_pkg::odt_stat_t     stat
);
    import odt_pkg::*;

    // two-flop synchronisers
    logic [1:0] ckSync, ckeSync, odtSync;
    logic       ckPrev;
    logic       ckRise;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            // idle levels: no false link edge right after reset
            ckSync  <= 2'b11;
            ckeSync <= 2'b11;
            odtSync <= 2'b00;
            ckPrev  <= 1'b1;
        end else begin
            ckSync  <= {ckSync[0], linkClk};
            ckeSync <= {ckeSync[0], cke};
            odtSync <= {odtSync[0], odt};
            ckPrev  <= ckSync[1];
        end
    end
    assign ckRise = ckSync[1] & ~ckPrev;

    // registered on link rising edges
    logic ckeReg, odtReg;
    logic next_ckeReg, next_odtReg;
    always_comb begin
        next_ckeReg = ckeReg;
        next_odtReg = odtReg;
        if (ckRise) begin
            next_ckeReg = ckeSync[1];
            next_odtReg = odtSync[1];
        end
    end
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ckeReg <= 1'b1;
            odtReg <= 1'b0;
        end else begin
            ckeReg <= next_ckeReg;
            odtReg <= next_odtReg;
        end
    end

    function automatic logic [5:0] writeLat(input odt_cfg_t c);
        writeLat = 6'({1'b0, c.casWriteLat} + {1'b0, c.addLat});
    endfunction

    // entry window length less one, in link clocks: the longer of the
    // anticipation interval and what is left of a running refresh;
    // the interval cannot be seen ahead, so it is laid after cke low
    function automatic logic [7:0] entryWin(input logic [7:0] rc, input logic [5:0] an);
        logic [7:0] fromRef;
        logic [7:0] fromAnpd;
        fromRef  = (rc > 8'h02) ? rc - 8'h02 : 8'h00;
        fromAnpd = (an > 6'h01) ? {2'b00, an - 6'h01} : 8'h00;
        entryWin = (fromRef > fromAnpd) ? fromRef : fromAnpd;
    endfunction

    logic [5:0] odtLat;
    logic [5:0] anpd;
    logic       termEn;
    always_comb begin
        odtLat = (writeLat(cfg) > ODTL_SUB) ? writeLat(cfg) - ODTL_SUB : LAT_RESET;
        anpd   = writeLat(cfg) - ANPD_SUB;
        termEn = cfg.rttNomOn | cfg.rttWrOn;
    end

    // sync path: odt delayed by cwl+al-2 link clocks
    logic syncTerm;
    odt_delay_line u_line (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .shiftEn (ckRise),
        .din     (odtReg),
        .tap     (odtLat),
        .dout    (syncTerm)
    );

    // mode tracking and transition windows
    odt_mode_t  mode;
    odt_mode_t  next_mode;
    logic [7:0] winCnt, next_winCnt;
    logic [7:0] refCnt, next_refCnt;
    logic       ckeFell, ckeRose;
    always_comb begin
        ckeFell     = ckRise & ckeReg & ~ckeSync[1];
        ckeRose     = ckRise & ~ckeReg & ckeSync[1];
        next_mode   = mode;
        next_winCnt = winCnt;
        next_refCnt = refCnt;
        if (refreshCmd && ckRise) begin
            next_refCnt = cfg.refreshCyc;
        end else if (ckRise && refCnt != 8'h00) begin
            next_refCnt = refCnt - 8'h01;
        end
        unique case (mode)
            MODE_SYNC: begin
                // entry window opened anpd before: count from cke low
                if (ckeFell && cfg.dllOffInPpd) begin
                    next_mode   = MODE_ENTRY;
                    next_winCnt = entryWin(refCnt, anpd);
                end
            end
            MODE_ENTRY: begin
                if (ckeRose) begin
                    // short low pulse: stay undefined through exit
                    next_mode   = MODE_EXIT;
                    next_winCnt = cfg.exitLockCyc;
                end else if (ckRise) begin
                    if (winCnt == 8'h00) begin
                        next_mode = MODE_ASYNC;
                    end else begin
                        next_winCnt = winCnt - 8'h01;
                    end
                end
            end
            MODE_ASYNC: begin
                if (ckeRose) begin
                    next_mode   = MODE_EXIT;
                    next_winCnt = cfg.exitLockCyc;
                end
            end
            MODE_EXIT: begin
                if (ckeFell && cfg.dllOffInPpd) begin
                    // short high pulse: window runs on into entry
                    next_mode   = MODE_ENTRY;
                    next_winCnt = entryWin(refCnt, anpd);
                end else if (ckRise) begin
                    if (winCnt == 8'h00) begin
                        next_mode = MODE_SYNC;
                    end else begin
                        next_winCnt = winCnt - 8'h01;
                    end
                end
            end
        endcase
        if (!cfg.dllOffInPpd && mode != MODE_SYNC) begin
            next_mode = MODE_SYNC;
        end
    end
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            mode   <= MODE_SYNC;
            winCnt <= 8'h00;
            refCnt <= 8'h00;
        end else begin
            mode   <= next_mode;
            winCnt <= next_winCnt;
            refCnt <= next_refCnt;
        end
    end

    // async path: fixed analog delay, no additive latency
    logic       asyncMode;
    logic       asyncTerm, next_asyncTerm;
    logic [3:0] asyncCnt, next_asyncCnt;
    logic       odtLvl;
    always_comb begin
        odtLvl    = odtSync[1];
        asyncMode = termEn & ((mode == MODE_ASYNC) | dllRelocking);
        next_asyncTerm = asyncTerm;
        next_asyncCnt  = asyncCnt;
        if (odtLvl == asyncTerm) begin
            next_asyncCnt = 4'h0;
        end else if (asyncCnt + 4'h1 >= ASYNC_DELAY) begin
            next_asyncTerm = odtLvl;
            next_asyncCnt  = 4'h0;
        end else begin
            next_asyncCnt = asyncCnt + 4'h1;
        end
    end
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            asyncTerm <= 1'b0;
            asyncCnt  <= 4'h0;
        end else begin
            asyncTerm <= next_asyncTerm;
            asyncCnt  <= next_asyncCnt;
        end
    end

    // output select; in windows either response is allowed
    odt_stat_t next_stat;
    always_comb begin
        next_stat.asyncMode  = asyncMode;
        next_stat.transition = termEn & ((mode == MODE_ENTRY) | (mode == MODE_EXIT));
        if (!termEn) begin
            next_stat.termOn = 1'b0;
        end else if (asyncMode) begin
            next_stat.termOn = asyncTerm;
        end else if (next_stat.transition) begin
            next_stat.termOn = asyncTerm;
        end else begin
            next_stat.termOn = syncTerm;
        end
    end
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            stat <= '0;
        end else begin
            stat <= next_stat;
        end
    end
endmodule // odt_mode_ctrl

// [tb/odt_mode_ctrl_chk.sv]
// checker: port-level assertions for the termination controller
`timescale 1ns/10ps
module odt_mode_ctrl_chk (
    // clock and reset
    input wire logic               clk_sys,
    input wire logic               resetn,
    // link pins
    input wire logic               linkClk,
    input wire logic               cke,
    input wire logic               odt,
    // device state and status
    input wire odt_pkg::odt_cfg_t  cfg,
    input wire logic               dllRelocking,
    input wire logic               refreshCmd,
    input wire odt_pkg::odt_stat_t stat
);
    import odt_pkg::*;
    logic [7:0] lowCnt;
    logic [7:0] hiCnt;
    logic       rttEn;
    assign rttEn = cfg.rttNomOn | cfg.rttWrOn;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // saturating cycle counts of cke low and high
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            lowCnt <= 8'h00;
            hiCnt  <= 8'h00;
        end else begin
            lowCnt <= cke ? 8'h00 : lowCnt + 8'(lowCnt != 8'hff);
            hiCnt  <= !cke ? 8'h00 : hiCnt + 8'(hiCnt != 8'hff);
        end
    end
    property p_off_no_term; !rttEn |-> !stat.termOn; endproperty
    a_off_no_term: assert property (p_off_no_term) else $error("term on while disabled");
    property p_relock; (rttEn && dllRelocking) [*8] |-> stat.asyncMode || stat.transition;
    endproperty
    a_relock: assert property (p_relock) else $error("not async while relocking");
    property p_async_on;
        rttEn && stat.asyncMode && !stat.transition && $rose(odt)
            |-> ##1 !stat.termOn ##[1:7] stat.termOn;
    endproperty
    a_async_on: assert property (p_async_on) else $error("async turn-on late");
    property p_async_off;
        rttEn && stat.asyncMode && !stat.transition && $fell(odt)
            |-> ##1 stat.termOn ##[1:7] !stat.termOn;
    endproperty
    a_async_off: assert property (p_async_off) else $error("async turn-off late");
    property p_no_window; !cfg.dllOffInPpd |-> !stat.transition; endproperty
    a_no_window: assert property (p_no_window) else $error("window with dll on");
    property p_pd_async; cfg.dllOffInPpd && rttEn && lowCnt == 8'hf0 |-> stat.asyncMode;
    endproperty
    a_pd_async: assert property (p_pd_async) else $error("power-down not async");
    property p_pd_sync;
        !cfg.dllOffInPpd && !dllRelocking && rttEn && lowCnt == 8'hf0 |-> !stat.asyncMode;
    endproperty
    a_pd_sync: assert property (p_pd_sync) else $error("async with dll on");
    property p_exit_start;
        cfg.dllOffInPpd && !dllRelocking && lowCnt > 8'h20 && $rose(cke)
            |-> ##[1:24] stat.transition;
    endproperty
    a_exit_start: assert property (p_exit_start) else $error("no exit window");
    property p_exit_end;
        hiCnt == 8'hf0 && !dllRelocking |-> !stat.transition && !stat.asyncMode;
    endproperty
    a_exit_end: assert property (p_exit_end) else $error("exit window too long");
endmodule // odt_mode_ctrl_chk

bind odt_mode_ctrl odt_mode_ctrl_chk u_chk (.clk_sys(clk_sys), .resetn(resetn),
    .linkClk(linkClk), .cke(cke), .odt(odt), .cfg(cfg), .dllRelocking(dllRelocking),
    .refreshCmd(refreshCmd), .stat(stat));

// [tb/odt_ctrl_model.sv]
// model: memory controller driving the link clock, cke and odt
`timescale 1ns/10ps
module odt_ctrl_model (
    // requests from the bench
    input  wire logic wantOdt,
    input  wire logic wantCke,
    input  wire logic readBurst,
    // link pins
    output logic      linkClk,
    output logic      cke,
    output logic      odt
);
    initial begin
        linkClk = 1'b0;
        cke = 1'b1;
        odt = 1'b0;
        forever #40 linkClk = ~linkClk;
    end
    // launched on the falling edge, registered at the next rise
    always @(negedge linkClk) begin
        cke <= wantCke;
        odt <= wantOdt & !readBurst;
    end
endmodule // odt_ctrl_model

// [tb/test_odt_mode_ctrl.sv]
// testbench: termination controller against a controller model
`timescale 1ns/10ps
module test_odt_mode_ctrl;
    import odt_pkg::*;
    logic        clk_sys, resetn, linkClk, cke, odt, dllRelocking, refreshCmd;
    logic        wantOdt, wantCke, readBurst;
    odt_cfg_t    cfg;
    odt_stat_t   stat;
    int          errors, num_checks, n, i, lat;
    logic [31:0] lfsr;

    odt_ctrl_model u_model (.wantOdt(wantOdt), .wantCke(wantCke), .readBurst(readBurst),
        .linkClk(linkClk), .cke(cke), .odt(odt));
    odt_mode_ctrl dut (.clk_sys(clk_sys), .resetn(resetn), .linkClk(linkClk), .cke(cke),
        .odt(odt), .cfg(cfg), .dllRelocking(dllRelocking), .refreshCmd(refreshCmd),
        .stat(stat));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] nextRand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic odt_cfg_t mk(input logic [1:0] en, input logic off,
                                    input int cwl, al, rfc, xl);
        return {en, off, 5'(cwl), 5'(al), 8'(rfc), 8'(xl)};
    endfunction
    function automatic int syncLat(input odt_cfg_t c);
        return (int'(c.casWriteLat) + int'(c.addLat) - 2) * 8;
    endfunction

    task automatic chk(input string what, input logic seen, input logic exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %b seen %b", what, exp, seen);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask
    // cycles until stat bit sel reaches lvl, bounded
    task automatic waitBit(input int sel, input logic lvl, output int cnt);
        for (cnt = 0; stat[sel] !== lvl; cnt++) begin
            if (cnt > 400) begin
                chk("wait bound", 1'b1, 1'b0);
                stop_test();
            end
            cyc(1);
        end
    endtask
    task automatic setOdt(input logic lvl, input logic rd, output int cnt);
        int k;
        wantOdt = lvl;
        readBurst = rd;
        for (k = 0; k < 20 && odt !== (lvl & !rd); k++) cyc(1);
        chk("odt pin", odt, lvl & !rd);
        waitBit(2, lvl & !rd, cnt);
    endtask
    task automatic rst(input odt_cfg_t c);
        resetn = 1'b0;
        cfg = c;
        cyc(5);
        resetn = 1'b1;
        cyc(20);
    endtask

    initial begin
        errors = 0;
        num_checks = 0;
        lfsr = 32'h0000_0624;
        {wantOdt, readBurst, dllRelocking, refreshCmd} = '0;
        wantCke = 1'b1;
        // relocking dll: async, additive latency ignored
        rst(mk(2'b11, 1'b0, 5, 4, 4, 6));
        dllRelocking = 1'b1;
        cyc(30);
        chk("asyncMode", stat.asyncMode, 1'b1);
        for (i = 0; i < 4; i++) begin
            lfsr = nextRand(lfsr);
            setOdt(1'b1, 1'b0, n);
            chk("async on", n inside {[2:8]}, 1'b1);
            cyc(12 + int'(lfsr[3:0]));
            setOdt(1'b0, 1'b0, n);
            chk("async off", n inside {[2:8]}, 1'b1);
            cyc(12);
        end
        dllRelocking = 1'b0;
        // synchronous latency over random write and additive latencies
        for (i = 0; i < 4; i++) begin
            lfsr = nextRand(lfsr);
            rst(mk(lfsr[5:4] | 2'b01, 1'b1, 5 + int'(lfsr[1:0]), int'(lfsr[3:2]), 4, 6));
            lat = syncLat(cfg);
            setOdt(1'b1, 1'b0, n);
            chk("sync on", n inside {[lat:lat + 10]}, 1'b1);
            cyc(20);
            setOdt(1'b1, 1'b1, n);
            chk("sync off", n inside {[lat:lat + 10]}, 1'b1);
            setOdt(1'b1, 1'b0, n);
            chk("sync reon", n inside {[lat:lat + 10]}, 1'b1);
            setOdt(1'b0, 1'b0, n);
            chk("sync drop", n inside {[lat:lat + 10]}, 1'b1);
        end
        // power-down with dll off; odt held still across windows
        rst(mk(2'b10, 1'b1, 5, 0, 12, 6));
        wantCke = 1'b0;
        cyc(300);
        chk("pd async", stat.asyncMode, 1'b1);
        setOdt(1'b1, 1'b0, n);
        chk("pd on", n inside {[2:8]}, 1'b1);
        wantCke = 1'b1;
        waitBit(0, 1'b1, n);
        waitBit(0, 1'b0, n);
        chk("exit len", n inside {[6 * 8:8 * 8]}, 1'b1);
        chk("exit sync", stat.asyncMode, 1'b0);
        refreshCmd = 1'b1;
        cyc(10);
        refreshCmd = 1'b0;
        wantCke = 1'b0;
        waitBit(0, 1'b1, n);
        waitBit(0, 1'b0, n);
        chk("entry len", n inside {[10 * 8:11 * 8]}, 1'b1);
        cyc(300);
        // short cke high pulse inside the exit window
        wantCke = 1'b1;
        waitBit(0, 1'b1, n);
        cyc(16);
        wantCke = 1'b0;
        cyc(16);
        wantCke = 1'b1;
        waitBit(0, 1'b0, n);
        chk("merged len", n inside {[6 * 8:8 * 8 + 16]}, 1'b1);
        // dll kept on in power-down: no window, stays synchronous
        rst(mk(2'b11, 1'b0, 5, 0, 4, 6));
        wantCke = 1'b0;
        cyc(300);
        chk("no window", stat.transition, 1'b0);
        chk("dll on sync", stat.asyncMode, 1'b0);
        wantCke = 1'b1;
        // termination disabled: odt has no effect
        rst(mk(2'b00, 1'b1, 5, 0, 4, 6));
        wantOdt = 1'b1;
        cyc(60);
        chk("term disabled", stat.termOn, 1'b0);
        stop_test();
    end
endmodule // test_odt_mode_ctrl
